// ==== hspc_top.sv ====
`timescale 1ns/1ps
`include "hspc_defs.svh"
module hspc_top
  import hspc_pkg::*;
(
  input  wire logic                    clk,     // 40 MHz clock
  input  wire logic                    nrst,    // Async reset, active low
  input  wire logic [7:0]              pins,    // Inputs base+0 .. base+7
  input  wire hspc_cfg_t [1:0]         cfg,     // Channel settings
  input  wire logic [1:0][1:0]         cmp_clr, // Clear compare outputs
  output logic [1:0][31:0]             count,   // Current counts
  output logic [1:0][1:0]              cmp_out  // Compare outputs
);

  localparam logic [5:0] DIV_LAST = 6'(`HSPC_INT_DIV - 1);
  // Match output follows equality by one cycle, far inside the 30 us bound
  localparam int MATCH_WIN = `HSPC_MATCH_WIN;

  hspc_st_t st_q;
  hspc_st_t st_d;

  function automatic logic sw_alloc(input hspc_mode_t m);
    return (m == HSPC_M_SWDIR) || (m == HSPC_M_INTCLK);
  endfunction

  function automatic logic [2:0] pin_a(input logic ch);
    return 3'(`HSPC_PIN_STRIDE * ch + `HSPC_PIN_A_OFS);
  endfunction

  function automatic logic [2:0] pin_b(input logic ch);
    return 3'(`HSPC_PIN_STRIDE * ch + `HSPC_PIN_B_OFS);
  endfunction

  function automatic logic [2:0] pin_p(input logic ch, input hspc_mode_t m);
    if (sw_alloc(m)) begin
      return 3'(`HSPC_PIN_STRIDE * ch + `HSPC_PIN_P_SW_OFS);
    end else begin
      return 3'(`HSPC_PIN_STRIDE * ch + `HSPC_PIN_P_OFS);
    end
  endfunction

  function automatic logic [2:0] pin_e(input logic ch);
    return 3'(`HSPC_PIN_ENA_BASE + ch);
  endfunction

  // Quadrature decode; simultaneous changes on both phases are all dropped in HSPC_E_X4 mode, half in HSPC_E_X1, none in HSPC_E_X2
  function automatic hspc_step_t quad_step(input logic a, input logic b,
                                           input logic pa, input logic pb,
                                           input hspc_edge_t em);
    logic ra;
    logic fa;
    logic rb;
    logic fb;
    logic up;
    logic dn;
    ra = a & ~pa;
    fa = ~a & pa;
    rb = b & ~pb;
    fb = ~b & pb;
    up = ra & ~b;
    dn = fa & ~b;
    if (em != HSPC_E_X1) begin
      up = up | (fa & b);
      dn = dn | (ra & b);
    end
    if (em == HSPC_E_X4) begin
      up = up | (rb & a) | (fb & ~a);
      dn = dn | (rb & ~a) | (fb & a);
    end
    if (up && !dn) begin
      return HSPC_S_UP;
    end else if (dn && !up) begin
      return HSPC_S_DN;
    end
    return HSPC_S_NONE;
  endfunction

  function automatic logic [31:0] next_cnt(input logic [31:0] v,
                                           input hspc_step_t s,
                                           input logic wide);
    logic [31:0] r;
    r = v;
    if (s == HSPC_S_UP) begin
      r = v + `HSPC_CNT_ONE;
    end else if (s == HSPC_S_DN) begin
      r = v - `HSPC_CNT_ONE;
    end
    if (!wide) begin
      r = r & `HSPC_W16_MASK;
    end
    return r;
  endfunction

  always_comb begin
    logic       a;
    logic       b;
    logic       p;
    logic       run;
    logic       chb;
    hspc_step_t s;
    a = 1'b0;
    b = 1'b0;
    p = 1'b0;
    run = 1'b0;
    chb = 1'b0;
    s = HSPC_S_NONE;
    st_d = st_q;
    // Divider for the 1 MHz internal count tick
    st_d.tick = 1'b0;
    if (st_q.div == DIV_LAST) begin
      st_d.div = `HSPC_DIV_RST;
      st_d.tick = 1'b1;
    end else begin
      st_d.div = st_q.div + 6'h01;
    end
    for (int c = 0; c < `HSPC_CH_NUM; c++) begin
      chb = 1'(c);
      a = pins[pin_a(chb)];
      b = pins[pin_b(chb)];
      p = pins[pin_p(chb, cfg[c].mode)];
      run = cfg[c].run_sw &
            (~cfg[c].ena_use | pins[pin_e(chb)]);
      case (cfg[c].mode)
        HSPC_M_SWDIR: begin
          if (a && !st_q.ch[c].pa) begin
            s = cfg[c].dir_sw ? HSPC_S_DN : HSPC_S_UP;
          end else begin
            s = HSPC_S_NONE;
          end
        end
        HSPC_M_HWDIR: begin
          if (a && !st_q.ch[c].pa) begin
            s = b ? HSPC_S_DN : HSPC_S_UP;
          end else begin
            s = HSPC_S_NONE;
          end
        end
        HSPC_M_DUAL: begin
          if ((a && !st_q.ch[c].pa) && !(b && !st_q.ch[c].pb)) begin
            s = HSPC_S_UP;
          end else if ((b && !st_q.ch[c].pb) && !(a && !st_q.ch[c].pa)) begin
            s = HSPC_S_DN;
          end else begin
            s = HSPC_S_NONE;
          end
        end
        HSPC_M_QUAD: begin
          s = quad_step(a, b, st_q.ch[c].pa, st_q.ch[c].pb,
                        cfg[c].edge_mul);
        end
        HSPC_M_INTCLK: begin
          if (st_q.tick) begin
            s = cfg[c].dir_sw ? HSPC_S_DN : HSPC_S_UP;
          end else begin
            s = HSPC_S_NONE;
          end
        end
        default: begin
          s = HSPC_S_NONE;
        end
      endcase
      st_d.ch[c].pa = a;
      st_d.ch[c].pb = b;
      st_d.ch[c].pp = p;
      // Preset edge overrides any count step in the same cycle
      if (cfg[c].preset_use && p && !st_q.ch[c].pp) begin
        st_d.ch[c].cnt = next_cnt(cfg[c].preset_val, HSPC_S_NONE,
                                  cfg[c].wide);
      end else if (run) begin
        st_d.ch[c].cnt = next_cnt(st_q.ch[c].cnt, s, cfg[c].wide);
      end else begin
        st_d.ch[c].cnt = next_cnt(st_q.ch[c].cnt, HSPC_S_NONE, cfg[c].wide);
      end
      // Sticky compare outputs; a new match wins over a clear
      for (int k = 0; k < 2; k++) begin
        if (st_q.ch[c].cnt == cfg[c].cmp_val[k]) begin
          st_d.ch[c].cmp[k] = 1'b1;
        end else if (cmp_clr[c][k]) begin
          st_d.ch[c].cmp[k] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs are plain copies of the state register
  assign count   = {st_q.ch[1].cnt, st_q.ch[0].cnt};
  assign cmp_out = {st_q.ch[1].cmp, st_q.ch[0].cmp};

  // Helper terms for channel 0 and channel 1 checks
  logic pr0;
  logic run0;
  logic pr1;
  assign pr0 = cfg[0].preset_use && pins[pin_p(1'b0, cfg[0].mode)] &&
               !st_q.ch[0].pp;
  assign pr1 = cfg[1].preset_use && pins[pin_p(1'b1, cfg[1].mode)] &&
               !st_q.ch[1].pp;
  assign run0 = cfg[0].run_sw && (!cfg[0].ena_use || pins[6]);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_a_rise_b_low;
    pins[0] && !st_q.ch[0].pa && !pins[1] && !st_q.ch[0].pb;
  endsequence

  sequence s_b_rise_a_high;
    pins[1] && !st_q.ch[0].pb && pins[0] && st_q.ch[0].pa;
  endsequence

  sequence s_counting(hspc_mode_t m);
    cfg[0].mode == m && cfg[0].wide && run0 && !pr0;
  endsequence

  a_quad_up: assert property (
    s_counting(HSPC_M_QUAD) and s_a_rise_b_low |=>
      count[0] == $past(count[0]) + `HSPC_CNT_ONE)
    else $error("quadrature A lead did not count up");

  a_x4_b_edge: assert property (
    s_counting(HSPC_M_QUAD) and s_b_rise_a_high and
      (cfg[0].edge_mul == HSPC_E_X4) |=>
      count[0] == $past(count[0]) + `HSPC_CNT_ONE)
    else $error("four-edge mode missed a B edge");

  a_x1_b_ignore: assert property (
    s_counting(HSPC_M_QUAD) and s_b_rise_a_high and
      (cfg[0].edge_mul == HSPC_E_X1) |=> $stable(count[0]))
    else $error("one-edge mode counted a B edge");

  a_dual_down: assert property (
    s_counting(HSPC_M_DUAL) and
      (pins[1] && !st_q.ch[0].pb && !(pins[0] && !st_q.ch[0].pa)) |=>
      count[0] == $past(count[0]) - `HSPC_CNT_ONE)
    else $error("dual-input B edge did not count down");

  a_hwdir_down: assert property (
    s_counting(HSPC_M_HWDIR) and (pins[0] && !st_q.ch[0].pa && pins[1]) |=>
      count[0] == $past(count[0]) - `HSPC_CNT_ONE)
    else $error("direction pin did not select down count");

  a_stop_hold: assert property (
    !cfg[0].run_sw && !pr0 |=> $stable(count[0]))
    else $error("count moved while stopped");

  a_ena_hold: assert property (
    cfg[0].ena_use && !pins[6] && !pr0 |=> $stable(count[0]))
    else $error("count moved with enable pin low");

  a_preset_odd: assert property (
    pr0 && cfg[0].wide |=> count[0] == $past(cfg[0].preset_val))
    else $error("odd channel preset not loaded");

  a_preset_even: assert property (
    cfg[1].mode == HSPC_M_SWDIR && cfg[1].wide && cfg[1].preset_use &&
      pins[4] && !st_q.ch[1].pp |=> count[1] == $past(cfg[1].preset_val))
    else $error("even channel preset pin not at base plus four");

  a_preset_load1: assert property (
    pr1 && cfg[1].wide |=> count[1] == $past(cfg[1].preset_val))
    else $error("even channel preset not loaded");

  a_match_set: assert property (
    count[0] == cfg[0].cmp_val[0] |-> ##[1:MATCH_WIN] cmp_out[0][0])
    else $error("compare output late");

  a_cmp_sticky: assert property (
    cmp_out[0][1] && !cmp_clr[0][1] |=> cmp_out[0][1])
    else $error("compare output dropped without clear");

  a_int_gap: assert property (
    cfg[0].mode == HSPC_M_INTCLK && !st_q.tick && !pr0 |=> $stable(count[0]))
    else $error("internal clock mode counted off tick");

  a_tick_gap: assert property (
    st_q.tick |=> !st_q.tick [*8])
    else $error("internal tick too frequent");

  a_w16_range: assert property (
    !cfg[0].wide && !$past(cfg[0].wide) |-> count[0][31:16] == 16'h0000)
    else $error("16-bit count exceeded range");

endmodule

// ==== hspc_defs.svh ====
`ifndef HSPC_DEFS_SVH
`define HSPC_DEFS_SVH

// Channel pair layout on the eight input pins
`define HSPC_CH_NUM       2
`define HSPC_PIN_NUM      8
`define HSPC_PIN_STRIDE   3
`define HSPC_PIN_A_OFS    0
`define HSPC_PIN_B_OFS    1
`define HSPC_PIN_P_SW_OFS 1
`define HSPC_PIN_P_OFS    2
`define HSPC_PIN_ENA_BASE 6

// Timing
`define HSPC_CLK_HZ       40000000
`define HSPC_CLK_NS       25
`define HSPC_INT_HZ       1000000
`define HSPC_INT_DIV      (`HSPC_CLK_HZ / `HSPC_INT_HZ)
`define HSPC_MATCH_NS     30000
`define HSPC_MATCH_CYC    (`HSPC_MATCH_NS / `HSPC_CLK_NS)
`define HSPC_MATCH_WIN    8

// Count values
`define HSPC_CNT_RST      32'h00000000
`define HSPC_CNT_ONE      32'h00000001
`define HSPC_W16_MASK     32'h0000FFFF
`define HSPC_DIV_RST      6'h00

`endif

// ==== hspc_pkg.sv ====
package hspc_pkg;

  typedef enum logic [2:0] {
    HSPC_M_SWDIR  = 3'h0,
    HSPC_M_HWDIR  = 3'h1,
    HSPC_M_DUAL   = 3'h2,
    HSPC_M_QUAD   = 3'h3,
    HSPC_M_INTCLK = 3'h4
  } hspc_mode_t;

  typedef enum logic [1:0] {
    HSPC_E_X1 = 2'h0,
    HSPC_E_X2 = 2'h1,
    HSPC_E_X4 = 2'h2
  } hspc_edge_t;

  typedef enum logic [1:0] {
    HSPC_S_NONE = 2'h0,
    HSPC_S_UP   = 2'h1,
    HSPC_S_DN   = 2'h2
  } hspc_step_t;

  typedef struct packed {
    hspc_mode_t        mode;
    hspc_edge_t        edge_mul;
    logic              preset_use;
    logic              ena_use;
    logic              run_sw;
    logic              dir_sw;
    logic              wide;
    logic [31:0]       preset_val;
    logic [1:0][31:0]  cmp_val;
  } hspc_cfg_t;

  typedef struct packed {
    logic        pa;
    logic        pb;
    logic        pp;
    logic [31:0] cnt;
    logic [1:0]  cmp;
  } hspc_ch_st_t;

  typedef struct packed {
    logic [5:0]             div;
    logic                   tick;
    hspc_ch_st_t [1:0]      ch;
  } hspc_st_t;

endpackage

// ==== hspc_enc_model.sv ====
`timescale 1ns/1ps
module hspc_enc_model (
  input  wire logic clk,  // Sampling clock
  input  wire logic nrst, // Reset, active low
  input  wire logic fwd,  // Quarter step, A leads
  input  wire logic rev,  // Quarter step, B leads
  output logic      pa,   // Phase A
  output logic      pb    // Phase B
);
  logic [1:0] ph_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ph_q <= 2'h0;
    end else if (fwd) begin
      ph_q <= ph_q + 2'h1;
    end else if (rev) begin
      ph_q <= ph_q - 2'h1;
    end
  end

  // Gray order 00,10,11,01: A leads B going forward
  assign pa = (ph_q == 2'h1) || (ph_q == 2'h2);
  assign pb = ph_q[1];
endmodule

// ==== test_high_speed_pulse_counter.sv ====
`timescale 1ns/1ps
module test_high_speed_pulse_counter;
  import hspc_pkg::*;
  logic             clk = 1'b0;
  logic             nrst = 1'b0;
  logic [7:2]       pin_q = 6'h00;
  logic             fwd = 1'b0;
  logic             rev = 1'b0;
  logic             enc_a;
  logic             enc_b;
  hspc_cfg_t [1:0]  cfg = '0;
  logic [1:0][1:0]  cmp_clr = 4'h0;
  logic [1:0][31:0] count;
  logic [1:0][1:0]  cmp_out;
  int               mismatches = 0;
  int               comparisons = 0;
  int               cycles = 0;

  always #12.5 clk = ~clk;

  hspc_enc_model enc (.clk(clk), .nrst(nrst), .fwd(fwd), .rev(rev),
                      .pa(enc_a), .pb(enc_b));
  hspc_top uut (.clk(clk), .nrst(nrst), .pins({pin_q, enc_b, enc_a}),
                .cfg(cfg), .cmp_clr(cmp_clr), .count(count),
                .cmp_out(cmp_out));

  task automatic final_report();
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches = mismatches + 1;
      final_report();
    end
  end

  task automatic rng(input logic [31:0] got, input logic [31:0] lo,
                     input logic [31:0] hi);
    comparisons++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask

  function automatic hspc_cfg_t mk(input hspc_mode_t md,
                                   input hspc_edge_t em);
    hspc_cfg_t c;
    c = '0;
    c.mode = md;
    c.edge_mul = em;
    c.run_sw = 1'b1;
    c.wide = 1'b1;
    return c;
  endfunction

  task automatic rst();
    @(posedge clk);
    nrst <= 1'b0;
    wait_n(20);
    nrst <= 1'b1;
    wait_n(2);
  endtask

  task automatic pulse(input int i, input int n);
    repeat (n) begin
      @(posedge clk);
      pin_q[i] <= 1'b1;
      wait_n(2);
      pin_q[i] <= 1'b0;
      wait_n(2);
    end
    wait_n(3);
  endtask

  // Preset and enable pins change at 10 kHz or slower
  task automatic slow_set(input int i, input logic v);
    @(posedge clk);
    pin_q[i] <= v;
    wait_n(2000);
  endtask

  task automatic step(input logic up, input int n);
    repeat (n) begin
      @(posedge clk);
      fwd <= up;
      rev <= !up;
      @(posedge clk);
      fwd <= 1'b0;
      rev <= 1'b0;
      wait_n(6);
    end
  endtask

  task automatic t_quad();
    logic [31:0] m;
    for (int e = 0; e < 3; e++) begin
      cfg[0] <= mk(HSPC_M_QUAD, hspc_edge_t'(e));
      rst();
      m = 32'h00000001 << e;
      step(1'b1, 4);
      chk(count[0], m);
      step(1'b0, 8);
      chk(count[0], -m);
    end
  endtask

  task automatic t_modes();
    cfg[1] <= mk(HSPC_M_SWDIR, HSPC_E_X1);
    rst();
    pulse(3, 3);
    chk(count[1], 32'h00000003);
    cfg[1].dir_sw <= 1'b1;
    pulse(3, 1);
    chk(count[1], 32'h00000002);
    cfg[1] <= mk(HSPC_M_HWDIR, HSPC_E_X1);
    pulse(3, 1);
    chk(count[1], 32'h00000003);
    pin_q[4] <= 1'b1;
    pulse(3, 2);
    chk(count[1], 32'h00000001);
    pin_q[4] <= 1'b0;
    cfg[1] <= mk(HSPC_M_DUAL, HSPC_E_X1);
    rst();
    pulse(3, 2);
    pulse(4, 3);
    chk(count[1], 32'hFFFFFFFF);
  endtask

  task automatic t_run();
    hspc_cfg_t c;
    c = mk(HSPC_M_SWDIR, HSPC_E_X1);
    c.run_sw = 1'b0;
    cfg[1] <= c;
    rst();
    pulse(3, 2);
    chk(count[1], 32'h00000000);
    c.run_sw = 1'b1;
    c.ena_use = 1'b1;
    cfg[1] <= c;
    pulse(3, 2);
    chk(count[1], 32'h00000000);
    slow_set(7, 1'b1);
    pulse(3, 2);
    chk(count[1], 32'h00000002);
    slow_set(7, 1'b0);
    cfg[1].ena_use <= 1'b0;
    pulse(3, 1);
    chk(count[1], 32'h00000003);
  endtask

  task automatic t_preset();
    hspc_cfg_t c0;
    hspc_cfg_t c1;
    c0 = mk(HSPC_M_QUAD, HSPC_E_X1);
    c0.preset_use = 1'b1;
    c0.preset_val = 32'h12345678;
    c1 = mk(HSPC_M_SWDIR, HSPC_E_X1);
    c1.preset_use = 1'b1;
    c1.preset_val = 32'h0000ABCD;
    cfg <= {c1, c0};
    rst();
    chk(cmp_out[1], 32'h00000003);
    slow_set(2, 1'b1);
    chk(count[0], 32'h12345678);
    slow_set(4, 1'b1);
    chk(count[1], 32'h0000ABCD);
    step(1'b1, 1);
    chk(count[0], 32'h12345679);
    slow_set(2, 1'b0);
    cfg[0].preset_use <= 1'b0;
    slow_set(2, 1'b1);
    chk(count[0], 32'h12345679);
  endtask

  task automatic t_int();
    hspc_cfg_t c;
    c = mk(HSPC_M_INTCLK, HSPC_E_X1);
    c.ena_use = 1'b1;
    cfg[0] <= c;
    rst();
    wait_n(200);
    chk(count[0], 32'h00000000);
    slow_set(6, 1'b1);
    rng(count[0], 32'h00000031, 32'h00000033);
    cfg[0].dir_sw <= 1'b1;
    wait_n(800);
    rng(count[0], 32'h0000001C, 32'h00000020);
  endtask

  task automatic t_cmp();
    hspc_cfg_t c;
    c = mk(HSPC_M_QUAD, HSPC_E_X4);
    c.wide = 1'b0;
    c.cmp_val = {32'h0000FFFF, 32'h00000003};
    cfg[0] <= c;
    rst();
    chk(cmp_out[0], 32'h00000000);
    step(1'b1, 3);
    chk(cmp_out[0], 32'h00000001);
    step(1'b1, 1);
    cmp_clr[0] <= 2'h1;
    wait_n(2);
    cmp_clr[0] <= 2'h0;
    wait_n(2);
    chk(cmp_out[0], 32'h00000000);
    step(1'b0, 5);
    chk(count[0], 32'h0000FFFF);
    chk(cmp_out[0], 32'h00000003);
    cfg[0].run_sw <= 1'b0;
    step(1'b1, 2);
    chk(count[0], 32'h0000FFFF);
  endtask

  initial begin
    rst();
    t_quad();
    t_modes();
    t_run();
    t_preset();
    t_int();
    t_cmp();
    final_report();
  end
endmodule
